// ==== include/dsc_pkg.sv ====
// shared constants and types of the demand-station control block
package dsc_pkg;

    localparam int UNITS     = 10;
    localparam int UNIT_W    = 4;
    localparam int LINES     = 9;
    localparam int LS_LINES  = 12;
    localparam int HS_LINES  = 4;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_TEST_READY = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DEMAND_IN  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LINE_SET   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_TEST_COND  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_HANDOFF    = 8'h14;

    // write fields: three v-section characters and a unit number
    localparam int CHAR_W    = 8;
    localparam int CHAR_LOW  = 3;
    localparam int UNIT_LSB  = 24;
    localparam int COND_SEL_W = 2;

    // status fields
    localparam int ST_ON_DEMAND = 0;
    localparam int ST_UNIT_LSB  = 1;
    localparam int ST_NOT_READY = 5;
    localparam int ST_SPECIAL   = 6;
    localparam int ST_PROBE     = 7;
    localparam int ST_COND_LSB  = 8;
    localparam int ST_READY_LSB = 16;

    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    // four-bit tape commands carried on lines a..d of the outgoing set
    localparam logic [3:0] TAPE_READ_FWD    = 4'h1;
    localparam logic [3:0] TAPE_SEARCH_EQ   = 4'h2;
    localparam logic [3:0] TAPE_SEARCH_GE   = 4'h3;
    localparam logic [3:0] TAPE_WIND        = 4'h4;
    localparam logic [3:0] TAPE_WRITE       = 4'h6;
    localparam logic [3:0] TAPE_WRITE_CHK   = 4'h7;
    localparam logic [3:0] TAPE_BUF_TO_TRK  = 4'h8;
    localparam logic [3:0] TAPE_READ_BWD    = 4'h9;
    localparam logic [3:0] TAPE_SEARCH_BEQ  = 4'hA;
    localparam logic [3:0] TAPE_SEARCH_BLE  = 4'hB;
    localparam logic [3:0] TAPE_REWIND      = 4'hC;
    localparam logic [3:0] TAPE_REWIND_LOCK = 4'hD;
    localparam logic [3:0] TAPE_TRK_TO_BUF  = 4'hF;

    typedef struct packed {
        logic [UNITS-1:0]    ready;
        logic [UNITS-1:0]    dtest;
        logic [UNITS-1:0]    dmd;
        logic [LS_LINES-1:0] ls;
        logic [HS_LINES-1:0] hs;
    } dsc_pins_t;

endpackage

// ==== design/dsc_station.sv ====
// demand-station control: ready test, demand, outgoing lines, condition storage
//
// Function
// (RULE1) low nine v bits drive lines a..i
// (RULE2) any character with right low bits works
// (RULE3) tape uses only lines a..d as code
// (RULE4) tape forward and track-to-buffer command codes
// (RULE5) tape backward, rewind and buffer-to-track codes
// (RULE6) low-speed lines live only while on demand
// (RULE7) low-speed lines steer program only via wiring
// (RULE8) peripheral reports conditions on lines w..z
// (RULE9) condition found: special-out exit, latch lines
// (RULE10) hold condition code, probe each line singly
// (RULE11) peripheral ready only when idle, error free
// (RULE12) ready test branches v if ready, else w
// (RULE13) test pulse gives ready or not-ready pulse
// (RULE14) ten units with test, ready, not-ready pins
// (RULE15) demand-in puts selected unit alone on demand
// (RULE16) track references allowed only while on demand
// (RULE17) demand-ground asserted while unit on demand
// (RULE18) demand-in pulse gives one out pulse
// (RULE19) lines reach only on-demand ready unit
// (RULE20) demand holds until i/o instruction or replaced
// (RULE21) use three low bits of each character
// (RULE22) new demand clears stale condition latch
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module dsc_station (
    // clock, reset, enable
    input  wire logic                           CLK_SYS,
    input  wire logic                           RST_B,
    input  wire logic                           CE,
    // register port
    input  wire logic [dsc_pkg::ADDR_W-1:0]     ADDR,
    input  wire logic [dsc_pkg::DATA_W-1:0]     WDATA,
    input  wire logic                           WR,
    input  wire logic                           RD,
    output logic      [dsc_pkg::DATA_W-1:0]     RDATA,
    // unit pins in
    input  wire logic [dsc_pkg::UNITS-1:0]      UNIT_READY,
    input  wire logic [dsc_pkg::UNITS-1:0]      DEMAND_TEST_IN,
    input  wire logic [dsc_pkg::UNITS-1:0]      DEMAND_IN,
    input  wire logic [dsc_pkg::LS_LINES-1:0]   LS_LINE_IN,
    input  wire logic [dsc_pkg::HS_LINES-1:0]   HS_LINE_IN,
    // continuation pulses
    output logic      [dsc_pkg::UNITS-1:0]      READY_OUT,
    output logic      [dsc_pkg::UNITS-1:0]      NOT_READY_OUT,
    output logic      [dsc_pkg::UNITS-1:0]      DEMAND_OUT,
    output logic      [dsc_pkg::UNITS-1:0]      SPECIAL_OUT,
    // demand levels
    output logic      [dsc_pkg::UNITS-1:0]      DEMAND_GND,
    output logic      [dsc_pkg::UNITS-1:0]      TRACK_REF_EN,
    output logic      [dsc_pkg::LS_LINES-1:0]   LS_SELECT,
    // outgoing lines
    output logic      [dsc_pkg::LINES-1:0]      OUT_LINE,
    output logic      [dsc_pkg::UNITS-1:0]      OUT_UNIT,
    output logic                                HANDOFF_PULSE
);
    import dsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [LINES-1:0] v_pattern(input logic [DATA_W-1:0] w);
        v_pattern = {w[2*CHAR_W +: CHAR_LOW], w[CHAR_W +: CHAR_LOW],
                     w[0 +: CHAR_LOW]}; // RULE21 RULE2
    endfunction

    function automatic logic [UNITS-1:0] one_hot(input logic [UNIT_W-1:0] u);
        one_hot = '0;
        for (int i = 0; i < UNITS; i++) begin
            if (u == UNIT_W'(i)) begin
                one_hot[i] = 1'b1;
            end
        end
    endfunction

    function automatic logic [UNIT_W-1:0] lowest(input logic [UNITS-1:0] v);
        lowest = '0;
        for (int i = UNITS - 1; i >= 0; i--) begin
            if (v[i]) begin
                lowest = UNIT_W'(i);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, a change counts when stages two and three agree

    dsc_pins_t pins_raw;
    dsc_pins_t sync1;
    dsc_pins_t sync2;
    dsc_pins_t sync3;
    dsc_pins_t pins;
    dsc_pins_t pins_d;

    assign pins_raw = '{ready: UNIT_READY, dtest: DEMAND_TEST_IN, dmd: DEMAND_IN,
                        ls: LS_LINE_IN, hs: HS_LINE_IN};

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            sync1  <= '0;
            sync2  <= '0;
            sync3  <= '0;
            pins   <= '0;
            pins_d <= '0;
        end else if (CE) begin
            sync1  <= pins_raw;
            sync2  <= sync1;
            sync3  <= sync2;
            pins   <= (sync2 & sync3) | (pins & (sync2 | sync3));
            pins_d <= pins;
        end
    end

    logic [UNITS-1:0] test_rise;
    logic [UNITS-1:0] dmd_rise;
    assign test_rise = pins.dtest & ~pins_d.dtest;
    assign dmd_rise  = pins.dmd & ~pins_d.dmd;

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    logic wr_test;
    logic wr_demand;
    logic wr_lines;
    logic wr_cond;
    logic wr_handoff;
    logic [UNIT_W-1:0] wr_unit;
    logic wr_unit_ok;

    assign wr_test    = WR && ADDR == OFS_TEST_READY;
    assign wr_demand  = WR && ADDR == OFS_DEMAND_IN;
    assign wr_lines   = WR && ADDR == OFS_LINE_SET;
    assign wr_cond    = WR && ADDR == OFS_TEST_COND;
    assign wr_handoff = WR && ADDR == OFS_HANDOFF;
    assign wr_unit    = WDATA[UNIT_LSB +: UNIT_W];
    assign wr_unit_ok = wr_unit < UNIT_W'(UNITS);

    ////////////////////////////////////////////////////////////////////////////
    // demand state: one unit at most, pin demand takes the cycle over a register one

    logic                on_demand;
    logic [UNIT_W-1:0]   dmd_unit;
    logic [HS_LINES-1:0] cond;
    logic                special;
    logic                new_demand;
    logic [UNIT_W-1:0]   next_unit;

    assign new_demand = (|dmd_rise) || (wr_demand && wr_unit_ok);
    assign next_unit  = (|dmd_rise) ? lowest(dmd_rise) : wr_unit;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            on_demand <= 1'b0;
            dmd_unit  <= '0;
        end else if (CE) begin
            if (new_demand) begin
                on_demand <= 1'b1; // RULE15 RULE20
                dmd_unit  <= next_unit;
            end else if (wr_lines) begin
                on_demand <= 1'b0; // RULE20
            end
        end
    end

    // condition latch: replaced on each new demand so stale codes never carry over
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            cond    <= '0;
            special <= 1'b0;
        end else if (CE) begin
            if (new_demand) begin
                cond    <= pins.hs; // RULE9 RULE22 RULE8
                special <= |pins.hs; // RULE9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // continuation pulses for the wired path

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            READY_OUT     <= '0;
            NOT_READY_OUT <= '0;
            DEMAND_OUT    <= '0;
            SPECIAL_OUT   <= '0;
        end else if (CE) begin
            READY_OUT     <= test_rise & pins.ready; // RULE13 RULE14
            NOT_READY_OUT <= test_rise & ~pins.ready; // RULE13
            DEMAND_OUT    <= '0;
            SPECIAL_OUT   <= '0;
            if (|dmd_rise) begin
                if (|pins.hs) begin
                    SPECIAL_OUT <= one_hot(next_unit); // RULE18 RULE9
                end else begin
                    DEMAND_OUT  <= one_hot(next_unit); // RULE18
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // demand levels and low-speed selector lines

    logic [UNITS-1:0] dmd_hot;
    assign dmd_hot = on_demand ? one_hot(dmd_unit) : '0;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            DEMAND_GND   <= '0;
            TRACK_REF_EN <= '0;
            LS_SELECT    <= '0;
        end else if (CE) begin
            DEMAND_GND   <= dmd_hot; // RULE17
            TRACK_REF_EN <= dmd_hot; // RULE16
            LS_SELECT    <= on_demand ? pins.ls : '0; // RULE6 RULE7
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outgoing lines: one-cycle pattern toward the on-demand ready unit

    logic [UNITS-1:0] line_target;
    assign line_target = dmd_hot & pins.ready;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            OUT_LINE <= '0;
            OUT_UNIT <= '0;
        end else if (CE) begin
            OUT_LINE <= '0;
            OUT_UNIT <= '0;
            if (wr_lines && |line_target) begin
                OUT_LINE <= v_pattern(WDATA); // RULE1 RULE3
                OUT_UNIT <= line_target; // RULE19
            end
        end
    end

    // wired-path handoff pulse for programs that act on low-speed lines
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            HANDOFF_PULSE <= 1'b0;
        end else if (CE) begin
            HANDOFF_PULSE <= wr_handoff; // RULE7
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction results: ready-test branch and condition probe

    logic not_ready;
    logic probe;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            not_ready <= 1'b0;
            probe     <= 1'b0;
        end else if (CE) begin
            if (wr_test && wr_unit_ok) begin
                not_ready <= ~pins.ready[wr_unit]; // RULE12
            end
            if (wr_cond) begin
                probe <= cond[WDATA[COND_SEL_W-1:0]]; // RULE10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: data in the cycle after the strobe, zero elsewhere

    logic [DATA_W-1:0] status;

    always_comb begin
        status                                 = ZERO_WORD;
        status[ST_ON_DEMAND]                   = on_demand;
        status[ST_UNIT_LSB +: UNIT_W]          = dmd_unit;
        status[ST_NOT_READY]                   = not_ready;
        status[ST_SPECIAL]                     = special;
        status[ST_PROBE]                       = probe;
        status[ST_COND_LSB +: HS_LINES]        = cond;
        status[ST_READY_LSB +: UNITS]          = pins.ready;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            RDATA <= ZERO_WORD;
        end else if (CE) begin
            RDATA <= (RD && ADDR == OFS_STATUS) ? status : ZERO_WORD;
        end
    end

endmodule

// ==== testbench/dsc_station_chk.sv ====
// port assertions of the demand-station control block
`timescale 1ns/1ps
module dsc_station_chk
    import dsc_pkg::*;
(
    // clock and bus
    input wire logic        CLK_SYS,
    input wire logic        RST_B,
    input wire logic        CE,
    input wire logic [7:0]  ADDR,
    input wire logic        WR,
    // watched outputs
    input wire logic [9:0]  READY_OUT,
    input wire logic [9:0]  NOT_READY_OUT,
    input wire logic [9:0]  DEMAND_OUT,
    input wire logic [9:0]  SPECIAL_OUT,
    input wire logic [9:0]  DEMAND_GND,
    input wire logic [9:0]  TRACK_REF_EN,
    input wire logic [11:0] LS_SELECT,
    input wire logic [8:0]  OUT_LINE,
    input wire logic [9:0]  OUT_UNIT,
    input wire logic        HANDOFF_PULSE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    chk_line_target: assert property (OUT_LINE != 9'h000 |-> $onehot(OUT_UNIT))
        else $error("outgoing lines without a single target");
    // demand ground and the line pulse leave the same edge, so both reflect one demand state
    chk_line_demand: assert property (
        OUT_UNIT != 10'h000 |-> (OUT_UNIT & DEMAND_GND) == OUT_UNIT)
        else $error("outgoing lines sent to a unit not on demand");
    chk_demand_single: assert property ($onehot0(DEMAND_GND))
        else $error("more than one unit on demand");
    chk_track_ref: assert property (TRACK_REF_EN == DEMAND_GND)
        else $error("track reference enable differs from demand");
    chk_ls_gated: assert property (
        DEMAND_GND == 10'h000 && $past(DEMAND_GND) == 10'h000 |-> LS_SELECT == 12'h000)
        else $error("low-speed lines live while no unit on demand");
    chk_exit_single: assert property (
        (DEMAND_OUT | SPECIAL_OUT) != 10'h000 |->
            $onehot(DEMAND_OUT | SPECIAL_OUT) ##1 (DEMAND_OUT | SPECIAL_OUT) == 10'h000)
        else $error("demand continuation not a single pulse");
    chk_test_single: assert property (
        (READY_OUT | NOT_READY_OUT) != 10'h000 |->
            $onehot(READY_OUT | NOT_READY_OUT) ##1 (READY_OUT | NOT_READY_OUT) == 10'h000)
        else $error("ready test answer not a single pulse");
    chk_demand_ground: assert property (
        (DEMAND_OUT | SPECIAL_OUT) != 10'h000 |=>
            DEMAND_GND == $past(DEMAND_OUT | SPECIAL_OUT))
        else $error("demand ground does not follow the demanded unit");
    chk_handoff_pulse: assert property (CE && WR && ADDR == OFS_HANDOFF |-> ##[1:2] HANDOFF_PULSE)
        else $error("handoff write gave no pulse");
endmodule
bind dsc_station dsc_station_chk dsc_station_chk_i (.CLK_SYS, .RST_B, .CE, .ADDR, .WR, .READY_OUT,
    .NOT_READY_OUT, .DEMAND_OUT, .SPECIAL_OUT, .DEMAND_GND, .TRACK_REF_EN, .LS_SELECT, .OUT_LINE,
    .OUT_UNIT, .HANDOFF_PULSE);

// ==== testbench/dsc_unit_model.sv ====
// peripheral units: ready, condition and low-speed lines, tape command decode
`timescale 1ns/1ps
module dsc_unit_model (
    // from the station
    input  wire logic        clk,
    input  wire logic [8:0]  out_line,
    input  wire logic [9:0]  out_unit,
    input  wire logic [9:0]  demand_gnd,
    // bench controls
    input  wire logic [9:0]  err,
    input  wire logic [3:0]  hs_set,
    input  wire logic [11:0] ls_set,
    // to the station
    output logic      [9:0]  unit_ready,
    output logic      [3:0]  hs_line,
    output logic      [11:0] ls_line,
    output logic      [3:0]  tape_cmd
);
    logic [9:0] busy = 10'h000;
    logic [4:0] busy_cnt = 5'h00;
    logic [2:0] tick = 3'h0;
    initial begin
        ls_line = 12'h000;
        tape_cmd = 4'h0;
    end
    always @(posedge clk) begin
        tick <= tick + 3'h1;
        if (out_unit != 10'h000) begin
            busy <= busy | out_unit;
            busy_cnt <= 5'h14;
            tape_cmd <= out_line[3:0];
        end else if (busy_cnt != 5'h00) begin
            busy_cnt <= busy_cnt - 5'h01;
        end else begin
            busy <= 10'h000;
        end
        // released lines flip now and then so a missing gate shows
        if (demand_gnd != 10'h000) ls_line <= ls_set;
        else if (tick == 3'h0) ls_line <= ~ls_line;
    end
    assign unit_ready = ~err & ~busy;
    assign hs_line = hs_set;
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench of the demand-station control block
`timescale 1ns/1ps
module testbench;
    import dsc_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, wr_s = 1'b0, rd_s = 1'b0, handoff;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, v;
    logic [9:0] dt_in = 10'h000, dm_in = 10'h000, err = 10'h000, unit_ready;
    logic [9:0] ready_out, not_ready_out, demand_out, special_out, demand_gnd, track_en, out_unit;
    logic [3:0] hs = 4'h0, hs_line, tape_cmd;
    logic [11:0] ls = 12'h000, ls_line, ls_select;
    logic [8:0] out_line, pat;
    logic [31:0] mon [4];
    logic [3:0] codes [13] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC,
                              4'hD, 4'hF};
    int fail_count = 0, cmp_count = 0, u;
    always #5 clk = ~clk;
    assign mon[0] = {12'h000, ready_out, not_ready_out};
    assign mon[1] = {12'h000, demand_out, special_out};
    assign mon[2] = {13'h0000, out_unit, out_line};
    assign mon[3] = {31'h0000_0000, handoff};
    dsc_station dsc_station_i (.CLK_SYS(clk), .RST_B(rst_b), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .UNIT_READY(unit_ready), .DEMAND_TEST_IN(dt_in),
        .DEMAND_IN(dm_in), .LS_LINE_IN(ls_line), .HS_LINE_IN(hs_line), .READY_OUT(ready_out),
        .NOT_READY_OUT(not_ready_out), .DEMAND_OUT(demand_out), .SPECIAL_OUT(special_out),
        .DEMAND_GND(demand_gnd), .TRACK_REF_EN(track_en), .LS_SELECT(ls_select),
        .OUT_LINE(out_line), .OUT_UNIT(out_unit), .HANDOFF_PULSE(handoff));
    dsc_unit_model dsc_unit_model_i (.clk(clk), .out_line(out_line), .out_unit(out_unit),
        .demand_gnd(demand_gnd), .err(err), .hs_set(hs), .ls_set(ls), .unit_ready(unit_ready),
        .hs_line(hs_line), .ls_line(ls_line), .tape_cmd(tape_cmd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        // read data stand for the cycle after the strobe edge; take them at its closing edge
        @(posedge clk);
        v = rdata;
    endtask
    task automatic wait_on(input int i);
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            v = mon[i];
            if (v != 32'h0000_0000) return;
        end
        fail_count++;
        final_report();
    endtask
    function automatic logic [31:0] mkline(input logic [8:0] p);
        logic [31:0] w;
        w = $urandom;
        w[2:0] = p[2:0];
        w[10:8] = p[5:3];
        w[18:16] = p[8:6];
        return w;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h18ab));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        for (u = 0; u < 10; u++) begin
            err <= 10'($urandom);
            repeat (8) @(posedge clk);
            wr(OFS_TEST_READY, {4'h0, 4'(u), 24'h00_0000});
            rd(OFS_STATUS);
            chk({31'h0, v[ST_NOT_READY]}, {31'h0, err[u]});
            chk({22'h0, v[25:16]}, {22'h0, ~err});
            dt_in[u] <= 1'b1;
            wait_on(0);
            chk(v, {12'h0, ~err & (10'h001 << u), err & (10'h001 << u)});
            dt_in <= 10'h000;
            repeat (6) @(posedge clk);
        end
        err <= 10'h000;
        for (u = 0; u < 10; u++) begin
            hs <= (u == 5) ? 4'h0 : 4'($urandom);
            ls <= 12'($urandom);
            repeat (6) @(posedge clk);
            wr(OFS_DEMAND_IN, {4'h0, 4'(u), 24'h00_0000});
            repeat (8) @(posedge clk);
            rd(OFS_STATUS);
            chk({22'h0, v[11:8], v[6], v[4:0]}, {22'h0, hs, hs != 4'h0, 4'(u), 1'b1});
            chk({22'h0, demand_gnd}, {22'h0, 10'h001 << u});
            chk({22'h0, track_en}, {22'h0, 10'h001 << u});
            chk({20'h0, ls_select}, {20'h0, ls});
            for (int k = 0; k < 4; k++) begin
                wr(OFS_TEST_COND, k);
                rd(OFS_STATUS);
                chk({31'h0, v[ST_PROBE]}, {31'h0, hs[k]});
            end
        end
        for (int k = 0; k < 15; k++) begin
            pat = 9'($urandom);
            if (k < 13) pat[3:0] = codes[k];
            else pat = (k == 13) ? 9'h001 : 9'h100;
            u = k % 10;
            // units commanded earlier in this loop stay busy until the model's count runs out
            if (k == 10) repeat (30) @(posedge clk);
            wr(OFS_DEMAND_IN, {4'h0, 4'(u), 24'h00_0000});
            repeat (6) @(posedge clk);
            wr(OFS_LINE_SET, mkline(pat));
            wait_on(2);
            chk(v, {13'h0, 10'h001 << u, pat});
            @(posedge clk);
            chk({28'h0, tape_cmd}, {28'h0, pat[3:0]});
            chk({22'h0, demand_gnd}, 32'h0000_0000);
        end
        err <= 10'h001;
        wr(OFS_DEMAND_IN, 32'h0000_0000);
        repeat (8) @(posedge clk);
        wr(OFS_LINE_SET, mkline(9'h1FF));
        repeat (3) begin
            @(posedge clk);
            chk(mon[2], 32'h0000_0000);
        end
        err <= 10'h000;
        for (u = 0; u < 10; u++) begin
            hs <= (u % 3 == 0) ? 4'h0 : 4'($urandom);
            repeat (6) @(posedge clk);
            dm_in[u] <= 1'b1;
            wait_on(1);
            chk(v, (hs != 4'h0) ? 32'h1 << u : 32'h1 << (u + 10));
            dm_in <= 10'h000;
            repeat (6) @(posedge clk);
        end
        wr(OFS_HANDOFF, 32'h0000_0000);
        wait_on(3);
        chk(v, 32'h0000_0001);
        // a write while the enable is low must not be taken
        ce <= 1'b0;
        wr(OFS_HANDOFF, 32'h0000_0000);
        repeat (2) begin
            @(posedge clk);
            chk({31'h0, handoff}, 32'h0000_0000);
        end
        ce <= 1'b1;
        rd(8'h20);
        chk(v, 32'h0000_0000);
        final_report();
    end
endmodule
